// file: hw/mbd_crc16.sv
// crc-16 accumulator, one byte per enabled cycle
`timescale 1ns/100ps
module mbd_crc16 (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_clr,
    input wire logic i_en,
    input wire logic [7:0] i_byte,
    output logic [15:0] o_crc
);
    // ========================================
    // byte update
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] x;
        x = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++) begin
            x = x[0] ? ((x >> 1) ^ mbd_pkg::CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    logic [15:0] crc_r;
    logic [15:0] crc_nxt;

    always_comb begin
        crc_nxt = crc_r;
        if (i_clr) begin
            crc_nxt = mbd_pkg::CRC_INIT;
        end else if (i_en) begin
            crc_nxt = crc_byte(crc_r, i_byte);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            crc_r <= mbd_pkg::CRC_INIT;
        end else if (i_ce) begin
            crc_r <= crc_nxt;
        end
    end

    assign o_crc = crc_r;
endmodule

// file: hw/mbd_slave.sv
// query handler for diagnosis and multiple holding register writes
`timescale 1ns/100ps
module mbd_slave #(
    parameter int MAX_REGS = mbd_pkg::MAX_REGS
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_CE,
    input wire logic [7:0] I_SLAVE_ADDR,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_rx_end,
    output logic [7:0] o_tx_byte,
    output logic o_tx_valid,
    input wire logic i_tx_ready,
    output logic o_wr_en,
    output mbd_pkg::mbd_wr_s o_wr,
    input wire logic i_wr_err,
    input wire logic i_proc_busy,
    output logic o_busy
);
    localparam int RX_MAX = mbd_pkg::WR_HDR_LEN + 2 * MAX_REGS;

    if (MAX_REGS < 1 || MAX_REGS > mbd_pkg::MAX_REGS) begin : g_chk
        $error("MAX_REGS out of range");
    end

    // ========================================
    // reset release
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ========================================
    // state
    typedef enum logic [2:0] {
        ST_RX = 3'h0,
        ST_CHECK = 3'h1,
        ST_WRITE = 3'h2,
        ST_WRWAIT = 3'h3,
        ST_SEND = 3'h4,
        ST_CRCL = 3'h5,
        ST_CRCH = 3'h6
    } mbd_state_e;

    mbd_state_e state_r, state_nxt;
    logic [7:0] rx_buf_r [RX_MAX];
    logic [7:0] rx_buf_nxt [RX_MAX];
    logic [5:0] rx_cnt_r, rx_cnt_nxt;
    logic ovf_r, ovf_nxt;
    logic [7:0] resp_r [mbd_pkg::RESP_MAX];
    logic [7:0] resp_nxt [mbd_pkg::RESP_MAX];
    logic [2:0] resp_len_r, resp_len_nxt;
    logic [2:0] tx_idx_r, tx_idx_nxt;
    logic [4:0] wr_idx_r, wr_idx_nxt;
    logic [7:0] tx_byte_r, tx_byte_nxt;
    logic tx_valid_r, tx_valid_nxt;
    logic wr_en_r, wr_en_nxt;
    mbd_pkg::mbd_wr_s wr_r, wr_nxt;
    logic rx_crc_clr, rx_crc_en, tx_crc_clr, tx_crc_en;
    logic [15:0] rx_crc, tx_crc;

    function automatic logic [15:0] word_at(input logic [7:0] hi, input logic [7:0] lo);
        return {hi, lo};
    endfunction

    // ========================================
    // crc engines
    mbd_crc16 u_rx_crc (
        .i_clk(I_CLK),
        .i_rst_n(rst_n),
        .i_ce(I_CE),
        .i_clr(rx_crc_clr),
        .i_en(rx_crc_en),
        .i_byte(i_rx_byte),
        .o_crc(rx_crc)
    );

    mbd_crc16 u_tx_crc (
        .i_clk(I_CLK),
        .i_rst_n(rst_n),
        .i_ce(I_CE),
        .i_clr(tx_crc_clr),
        .i_en(tx_crc_en),
        .i_byte(tx_byte_r),
        .o_crc(tx_crc)
    );

    // ========================================
    // next state
    logic [15:0] start_w, count_w, sub_w;
    logic [7:0] bc_w;
    logic accept;
    always_comb begin
        start_w = word_at(rx_buf_r[mbd_pkg::POS_W0], rx_buf_r[mbd_pkg::POS_W0 + 1]);
        count_w = word_at(rx_buf_r[mbd_pkg::POS_W1], rx_buf_r[mbd_pkg::POS_W1 + 1]);
        sub_w = start_w;
        bc_w = rx_buf_r[mbd_pkg::POS_BC];
        accept = tx_valid_r && i_tx_ready;
        state_nxt = state_r;
        rx_buf_nxt = rx_buf_r;
        rx_cnt_nxt = rx_cnt_r;
        ovf_nxt = ovf_r;
        resp_nxt = resp_r;
        resp_len_nxt = resp_len_r;
        tx_idx_nxt = tx_idx_r;
        wr_idx_nxt = wr_idx_r;
        tx_byte_nxt = tx_byte_r;
        tx_valid_nxt = tx_valid_r;
        wr_en_nxt = 1'b0;
        wr_nxt = wr_r;
        rx_crc_clr = 1'b0;
        rx_crc_en = 1'b0;
        tx_crc_clr = 1'b0;
        tx_crc_en = 1'b0;
        case (state_r)
            ST_RX: begin
                // bytes arriving while a reply is pending are not seen here
                if (i_rx_valid) begin
                    rx_crc_en = 1'b1;
                    if (rx_cnt_r < 6'(RX_MAX)) begin
                        rx_buf_nxt[rx_cnt_r] = i_rx_byte;
                        rx_cnt_nxt = rx_cnt_r + 6'h01;
                    end else begin
                        ovf_nxt = 1'b1;
                    end
                end
                if (i_rx_end) begin
                    state_nxt = ST_CHECK;
                end
            end
            ST_CHECK: begin
                state_nxt = ST_RX;
                rx_cnt_nxt = 6'h00;
                ovf_nxt = 1'b0;
                rx_crc_clr = 1'b1;
                tx_idx_nxt = 3'h0;
                wr_idx_nxt = 5'h00;
                tx_crc_clr = 1'b1;
                // header latched only here so a later exception code is not overwritten
                resp_nxt[0] = rx_buf_r[mbd_pkg::POS_ADDR];
                resp_nxt[1] = rx_buf_r[mbd_pkg::POS_FC];
                // residue zero means crc (low byte first) matched
                // an overlong write still gets 03h; the header bytes are kept
                if (rx_crc == 16'h0000 && rx_cnt_r >= 6'(mbd_pkg::MIN_LEN)
                    && rx_buf_r[mbd_pkg::POS_ADDR] == I_SLAVE_ADDR) begin
                    if (rx_buf_r[mbd_pkg::POS_FC] == mbd_pkg::FC_DIAG
                        && rx_cnt_r == 6'(mbd_pkg::DIAG_LEN)) begin
                        state_nxt = ST_SEND;
                        if (sub_w == mbd_pkg::SUB_ECHO) begin
                            // echo; fresh crc equals the received one
                            for (int k = 2; k < mbd_pkg::RESP_MAX; k++) begin
                                resp_nxt[k] = rx_buf_r[k];
                            end
                            resp_len_nxt = 3'h6;
                        end else begin
                            resp_nxt[1] = rx_buf_r[mbd_pkg::POS_FC] | mbd_pkg::EXC_FLAG;
                            resp_nxt[2] = mbd_pkg::EXC_DATA;
                            resp_len_nxt = 3'h3;
                        end
                    end else if (rx_buf_r[mbd_pkg::POS_FC] == mbd_pkg::FC_WRMULTI) begin
                        state_nxt = ST_SEND;
                        for (int k = 2; k < mbd_pkg::RESP_MAX; k++) begin
                            resp_nxt[k] = rx_buf_r[k];
                        end
                        resp_len_nxt = 3'h6;
                        if (count_w == 16'h0000 || count_w > 16'(MAX_REGS)
                            || {8'h00, bc_w} != {count_w[14:0], 1'b0}
                            || ovf_r
                            || 32'(rx_cnt_r) != mbd_pkg::WR_HDR_LEN + 32'(bc_w)) begin
                            resp_nxt[1] = rx_buf_r[mbd_pkg::POS_FC] | mbd_pkg::EXC_FLAG;
                            resp_nxt[2] = mbd_pkg::EXC_DATA;
                            resp_len_nxt = 3'h3;
                        end else if (i_proc_busy) begin
                            resp_nxt[1] = rx_buf_r[mbd_pkg::POS_FC] | mbd_pkg::EXC_FLAG;
                            resp_nxt[2] = mbd_pkg::EXC_SLAVE;
                            resp_len_nxt = 3'h3;
                        end else begin
                            state_nxt = ST_WRITE;
                        end
                    end
                end
            end
            ST_WRITE: begin
                // ascending addresses, upper half at even index first
                wr_en_nxt = 1'b1;
                wr_nxt.addr = start_w + 16'(wr_idx_r);
                wr_nxt.data = word_at(rx_buf_r[mbd_pkg::POS_DATA + 2 * wr_idx_r],
                                      rx_buf_r[mbd_pkg::POS_DATA + 2 * wr_idx_r + 1]);
                state_nxt = ST_WRWAIT;
            end
            ST_WRWAIT: begin
                if (i_wr_err) begin
                    // earlier writes are kept; no rollback
                    resp_nxt[1] = rx_buf_r[mbd_pkg::POS_FC] | mbd_pkg::EXC_FLAG;
                    resp_nxt[2] = mbd_pkg::EXC_SLAVE;
                    resp_len_nxt = 3'h3;
                    state_nxt = ST_SEND;
                end else if (16'(wr_idx_r) + 16'h0001 == count_w) begin
                    state_nxt = ST_SEND;
                end else begin
                    wr_idx_nxt = wr_idx_r + 5'h01;
                    state_nxt = ST_WRITE;
                end
            end
            ST_SEND: begin
                if (!tx_valid_r) begin
                    tx_byte_nxt = resp_r[tx_idx_r];
                    tx_valid_nxt = 1'b1;
                end else if (accept) begin
                    tx_crc_en = 1'b1;
                    tx_valid_nxt = 1'b0;
                    tx_idx_nxt = tx_idx_r + 3'h1;
                    if (tx_idx_r + 3'h1 == resp_len_r) begin
                        state_nxt = ST_CRCL;
                    end
                end
            end
            ST_CRCL: begin
                if (!tx_valid_r) begin
                    tx_byte_nxt = tx_crc[7:0];
                    tx_valid_nxt = 1'b1;
                end else if (accept) begin
                    tx_valid_nxt = 1'b0;
                    state_nxt = ST_CRCH;
                end
            end
            ST_CRCH: begin
                if (!tx_valid_r) begin
                    tx_byte_nxt = tx_crc[15:8];
                    tx_valid_nxt = 1'b1;
                end else if (accept) begin
                    tx_valid_nxt = 1'b0;
                    state_nxt = ST_RX;
                end
            end
            default: begin
                state_nxt = ST_RX;
            end
        endcase
    end

    // ========================================
    // registers
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_RX;
            for (int k = 0; k < RX_MAX; k++) begin
                rx_buf_r[k] <= 8'h00;
            end
            for (int k = 0; k < mbd_pkg::RESP_MAX; k++) begin
                resp_r[k] <= 8'h00;
            end
            rx_cnt_r <= 6'h00;
            ovf_r <= 1'b0;
            resp_len_r <= 3'h0;
            tx_idx_r <= 3'h0;
            wr_idx_r <= 5'h00;
            tx_byte_r <= 8'h00;
            tx_valid_r <= 1'b0;
            wr_en_r <= 1'b0;
            wr_r <= '0;
        end else if (I_CE) begin
            state_r <= state_nxt;
            rx_buf_r <= rx_buf_nxt;
            resp_r <= resp_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            ovf_r <= ovf_nxt;
            resp_len_r <= resp_len_nxt;
            tx_idx_r <= tx_idx_nxt;
            wr_idx_r <= wr_idx_nxt;
            tx_byte_r <= tx_byte_nxt;
            tx_valid_r <= tx_valid_nxt;
            wr_en_r <= wr_en_nxt;
            wr_r <= wr_nxt;
        end
    end

    logic busy_r;
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
        end else if (I_CE) begin
            busy_r <= (state_nxt != ST_RX);
        end
    end

    assign o_tx_byte = tx_byte_r;
    assign o_tx_valid = tx_valid_r;
    assign o_wr_en = wr_en_r;
    assign o_wr = wr_r;
    assign o_busy = busy_r;
endmodule

// file: shared/mbd_pkg.sv
// shared constants and types for the diagnosis / multi-write query handler
package mbd_pkg;
    // ========================================
    // function codes and fields
    localparam logic [7:0] FC_DIAG = 8'h08;
    localparam logic [7:0] FC_WRMULTI = 8'h10;
    localparam logic [15:0] SUB_ECHO = 16'h0000;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_DATA = 8'h03;
    localparam logic [7:0] EXC_SLAVE = 8'h04;
    localparam int MAX_REGS = 16;
    // ========================================
    // frame layout (byte positions)
    localparam int POS_ADDR = 0;
    localparam int POS_FC = 1;
    localparam int POS_W0 = 2;
    localparam int POS_W1 = 4;
    localparam int POS_BC = 6;
    localparam int POS_DATA = 7;
    localparam int DIAG_LEN = 8;
    localparam int WR_HDR_LEN = 9;
    localparam int MIN_LEN = 4;
    localparam int RX_MAX = WR_HDR_LEN + 2 * MAX_REGS;
    localparam int RESP_MAX = 6;
    // ========================================
    // crc-16
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    // ========================================
    // register write request
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } mbd_wr_s;
endpackage

// file: sim/mbd_master_model.sv
// host side model: sends query frames, collects reply bytes
`timescale 1ns/100ps
module mbd_master_model (
    input wire logic clk,
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_end,
    output logic tx_ready
);
    // ========================================
    // reply capture, sink may stall every other cycle
    logic [7:0] resp[$];
    logic slow = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        rx_end = 1'b0;
        tx_ready = 1'b1;
    end
    always @(negedge clk) tx_ready <= !slow || !tx_ready;
    always @(posedge clk) if (tx_valid && tx_ready) resp.push_back(tx_byte);
    // ========================================
    // crc-16 and framing
    function automatic logic [15:0] crc16(input logic [7:0] f[$]);
        logic [15:0] c;
        c = mbd_pkg::CRC_INIT;
        foreach (f[i]) begin
            c = c ^ {8'h00, f[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ mbd_pkg::CRC_POLY : c >> 1;
        end
        return c;
    endfunction
    // bad flips one crc bit so a corrupted frame can be offered
    task automatic send(input logic [7:0] f[$], input logic bad);
        logic [15:0] c;
        c = crc16(f) ^ {15'h0000, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        foreach (f[i]) begin
            @(negedge clk);
            rx_valid = 1'b1;
            rx_byte = f[i];
            rx_end = (i == f.size() - 1);
        end
        @(negedge clk);
        rx_valid = 1'b0;
        rx_end = 1'b0;
        rx_byte = ~rx_byte; // idle line shows no stale byte
    endtask
endmodule

// file: sim/mbd_slave_checker.sv
// concurrent checks on the handler ports
`timescale 1ns/100ps
module mbd_slave_checker #(
    parameter int MAX_REGS = mbd_pkg::MAX_REGS
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_CE,
    input wire logic [7:0] I_SLAVE_ADDR,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_rx_end,
    input wire logic [7:0] o_tx_byte,
    input wire logic o_tx_valid,
    input wire logic i_tx_ready,
    input wire logic o_wr_en,
    input wire mbd_pkg::mbd_wr_s o_wr,
    input wire logic i_wr_err,
    input wire logic i_proc_busy,
    input wire logic o_busy
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);
    // ========================================
    // first reply byte flag, writes per frame
    logic first_r;
    logic [4:0] wcnt_r;
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            first_r <= 1'b1;
            wcnt_r <= 5'h00;
        end else if (!o_busy) begin
            first_r <= 1'b1;
            wcnt_r <= 5'h00;
        end else begin
            if (I_CE && o_tx_valid && i_tx_ready) first_r <= 1'b0;
            if (I_CE && o_wr_en) wcnt_r <= wcnt_r + 5'h01;
        end
    end
    // ========================================
    // assertions
    AST_TX_HOLD: assert property (I_CE && o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte))
        else $error("reply byte dropped or changed while stalled");
    AST_TX_GAP: assert property (I_CE && o_tx_valid && i_tx_ready |=> !o_tx_valid)
        else $error("reply byte not released after accept");
    AST_TX_ADDR: assert property (o_tx_valid && first_r |-> o_tx_byte == I_SLAVE_ADDR)
        else $error("reply does not start with own address");
    AST_WR_SPACING: assert property (I_CE && o_wr_en |=> !o_wr_en)
        else $error("write strobe longer than one cycle");
    AST_WR_ASCEND: assert property (o_wr_en ##2 o_wr_en |-> o_wr.addr == $past(o_wr.addr, 2) + 16'h0001)
        else $error("writes not in ascending address order");
    AST_WR_BUSY: assert property (o_wr_en |-> o_busy)
        else $error("write outside a frame");
    AST_WR_LIMIT: assert property (wcnt_r <= MAX_REGS)
        else $error("too many writes in one frame");
    AST_WR_ERR_STOP: assert property (I_CE && o_wr_en && i_wr_err |=> !o_wr_en [*8])
        else $error("write continued after rejection");
    COV_ERR: cover property (o_wr_en && i_wr_err);
    COV_STALL: cover property (o_tx_valid && !i_tx_ready);
    COV_FULL: cover property (wcnt_r == 5'h10);
endmodule
bind mbd_slave mbd_slave_checker #(.MAX_REGS(MAX_REGS)) u_chk (
    .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE), .I_SLAVE_ADDR(I_SLAVE_ADDR),
    .i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte), .i_rx_end(i_rx_end),
    .o_tx_byte(o_tx_byte), .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready),
    .o_wr_en(o_wr_en), .o_wr(o_wr), .i_wr_err(i_wr_err), .i_proc_busy(i_proc_busy),
    .o_busy(o_busy)
);

// file: sim/mbd_slave_tb.sv
// self-checking bench for the diagnosis / multi-write handler
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin error_cnt++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module mbd_slave_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] saddr = 8'h03;
    logic wr_err = 1'b0;
    logic proc_busy = 1'b0;
    logic ce = 1'b1;
    logic ce_gap = 1'b0;
    logic [15:0] err_addr = 16'hFFFF;
    logic rx_valid, rx_end, tx_valid, tx_ready, wr_en, busy;
    logic [7:0] rx_byte, tx_byte;
    mbd_pkg::mbd_wr_s wr;
    mbd_pkg::mbd_wr_s wq[$];
    int error_cnt = 0;
    int n_compared = 0;
    always #2.5 clk = ~clk;
    mbd_slave i_mbd_slave (
        .I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_SLAVE_ADDR(saddr),
        .i_rx_valid(rx_valid), .i_rx_byte(rx_byte), .i_rx_end(rx_end),
        .o_tx_byte(tx_byte), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready),
        .o_wr_en(wr_en), .o_wr(wr), .i_wr_err(wr_err), .i_proc_busy(proc_busy), .o_busy(busy)
    );
    mbd_master_model m_host (
        .clk(clk), .tx_byte(tx_byte), .tx_valid(tx_valid), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_end(rx_end), .tx_ready(tx_ready)
    );
    // ========================================
    // register sink, rejects one chosen address
    always @(posedge clk) if (wr_en && ce) wq.push_back(wr);
    // enable gaps only while no byte is offered, the sink cannot see the enable
    always @(negedge clk) ce <= !(ce_gap && busy && !tx_valid && ce);
    always @(negedge clk) wr_err <= wr_en && wr.addr == err_addr;
    task automatic tally_and_finish();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ========================================
    // shared helpers
    task automatic xfer(input logic [7:0] q[$], input logic bad);
        int t;
        m_host.resp.delete();
        wq.delete();
        m_host.send(q, bad);
        repeat (3) @(negedge clk);
        for (t = 0; t < 400 && busy !== 1'b0; t++) @(negedge clk);
        if (t == 400) begin
            `CHK("busy_timeout", 1'b0, 1'b1)
            tally_and_finish();
        end
        repeat (2) @(negedge clk);
    endtask
    task automatic wr_frame(input int n, input int bc, input logic bad);
        logic [7:0] f[$];
        f = {saddr, mbd_pkg::FC_WRMULTI, 8'h01, 8'h20, 8'h00, 8'(n), 8'(bc)};
        for (int i = 0; i < n; i++) f = {f, 8'hA0, 8'(i)};
        xfer(f, bad);
    endtask
    task automatic chk_frame(input logic [7:0] e[$]);
        logic [15:0] c;
        c = m_host.crc16(e);
        e = {e, c[7:0], c[15:8]};
        `CHK("resp_len", e.size(), m_host.resp.size())
        foreach (e[i]) `CHK("resp_byte", e[i], m_host.resp[i])
    endtask
    // ========================================
    // scenarios
    task automatic t_diag_echo();
        m_host.slow = 1'b1;
        xfer('{8'h03, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, 1'b0);
        chk_frame('{8'h03, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34});
        `CHK("diag_crc_lo", 8'hEC, m_host.resp[6])
        `CHK("diag_writes", 0, wq.size())
        m_host.slow = 1'b0;
    endtask
    task automatic t_write_ok();
        logic [15:0] v[6] = '{16'h0000, 16'h0002, 16'h0000, 16'h0032, 16'h0000, 16'h0096};
        saddr = 8'h04;
        xfer('{8'h04, 8'h10, 8'h06, 8'h00, 8'h00, 8'h06, 8'h0C, 8'h00, 8'h00, 8'h00, 8'h02,
            8'h00, 8'h00, 8'h00, 8'h32, 8'h00, 8'h00, 8'h00, 8'h96}, 1'b0);
        chk_frame('{8'h04, 8'h10, 8'h06, 8'h00, 8'h00, 8'h06});
        `CHK("wr_crc_hi", 8'hD6, m_host.resp[7])
        foreach (v[i]) `CHK("wr_reg", {16'h0600 + 16'(i), v[i]}, wq[i])
    endtask
    task automatic t_write_max();
        wr_frame(16, 32, 1'b0);
        chk_frame('{saddr, 8'h10, 8'h01, 8'h20, 8'h00, 8'h10});
        `CHK("max_count", 16, wq.size())
        `CHK("max_last", 32'h012F_A00F, wq[15])
    endtask
    task automatic t_bad_counts();
        int n[3] = '{17, 0, 2};
        int bc[3] = '{34, 0, 3};
        foreach (n[i]) begin
            wr_frame(n[i], bc[i], 1'b0);
            chk_frame('{saddr, 8'h90, 8'h03});
            `CHK("cnt_writes", 0, wq.size())
        end
    endtask
    task automatic t_reject();
        err_addr = 16'h0122;
        ce_gap = 1'b1;
        wr_frame(4, 8, 1'b0);
        ce_gap = 1'b0;
        chk_frame('{saddr, 8'h90, 8'h04});
        `CHK("kept_writes", 3, wq.size())
        err_addr = 16'hFFFF;
        proc_busy = 1'b1;
        wr_frame(2, 4, 1'b0);
        chk_frame('{saddr, 8'h90, 8'h04});
        `CHK("busy_writes", 0, wq.size())
        proc_busy = 1'b0;
    endtask
    task automatic t_drop_and_sub();
        wr_frame(2, 4, 1'b1);
        `CHK("drop_resp", 0, m_host.resp.size())
        `CHK("drop_writes", 0, wq.size())
        xfer('{8'h7E, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, 1'b0);
        `CHK("other_addr_resp", 0, m_host.resp.size())
        xfer('{saddr, 8'h08, 8'h00, 8'h01, 8'h12, 8'h34}, 1'b0);
        chk_frame('{saddr, 8'h88, 8'h03});
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_diag_echo();
        t_write_ok();
        t_write_max();
        t_bad_counts();
        t_reject();
        t_drop_and_sub();
        tally_and_finish();
    end
endmodule
